// file: dtc_timer.sv
// Dual 8-bit timer/event counter with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module dtc_timer
   import dtc_pkg::*;
#(
   parameter int FS_DIVIDE = FS_DIV
)
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic       [31:0] s_axi_wdata,
   input  wire logic        [3:0] s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic             [1:0] s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic            [31:0] s_axi_rdata,
   output logic             [1:0] s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              event_input_pin_lower,
   input  wire logic              event_input_pin_upper,
   input  wire logic              low_speed_mode,
   output logic                   match_interrupt_lower,
   output logic                   match_interrupt_upper
);
   // Prescaler counter must hold the divide value and wrap at least once
   if (FS_DIVIDE < 2 || FS_DIVIDE >= (1 << FS_CNT_W)) begin : g_bad_divide
      $error("FS_DIVIDE out of range");
   end

   typedef struct packed {
      logic                          aw_have;
      logic             [ADDR_W-1:0] aw_addr;
      logic                          w_have;
      logic                   [31:0] w_data;
      logic                    [3:0] w_strb;
      logic                          bvalid;
      logic                    [1:0] bresp;
      logic                          rvalid;
      logic                   [31:0] rdata;
      logic                    [1:0] rresp;
      logic               [1:0][7:0] ctrl;
      logic               [1:0][7:0] period;
      logic               [1:0][7:0] duty;
      logic                          tap_sel;
      logic     [1:0][SYNC_LEN-1:0]  ev_sync;
      logic              [PRE_W-1:0] pre;
      logic           [FS_CNT_W-1:0] fs_cnt;
      logic           [FS_SUB_W-1:0] fs_sub;
      logic                    [1:0] irq;
   } dtc_state_t;

   dtc_state_t st_reg;
   dtc_state_t st_next;

   logic [1:0][7:0] count;
   logic            carry_lo;
   logic      [1:0] run;
   logic      [1:0] tick;
   logic      [1:0] clear;
   logic      [1:0] fall;
   logic            upper16;
   logic            match16;
   logic      [1:0] match8;

   // ****************************************
   // Prescaled tick for a clock select code
   // ****************************************
   function automatic logic tap_tick(input logic [2:0] sel, input dtc_state_t s,
                                     input logic slow);
      logic fs_t;
      logic fs8_t;
      fs_t  = (s.fs_cnt == FS_CNT_W'(FS_DIVIDE - 1));
      fs8_t = fs_t & (&s.fs_sub);
      tap_tick = 1'b0;
      unique case (sel)
         SEL_SLOWEST: tap_tick = (slow | s.tap_sel) ? fs8_t : (&s.pre[10:0]);
         SEL_FC_128:  tap_tick = &s.pre[6:0];
         SEL_FC_32:   tap_tick = &s.pre[4:0];
         SEL_FC_8:    tap_tick = &s.pre[2:0];
         SEL_FS:      tap_tick = fs_t;
         SEL_FC_2:    tap_tick = s.pre[0];
         SEL_FC:      tap_tick = 1'b1;
         SEL_PIN:     tap_tick = 1'b0;
      endcase
   endfunction : tap_tick

   // Timer mode tap legality by power state
   function automatic logic timer_sel_ok(input logic [2:0] sel, input logic slow);
      if (slow) begin
         timer_sel_ok = (sel == SEL_SLOWEST);
      end else begin
         timer_sel_ok = (sel <= SEL_FC_8);
      end
   endfunction : timer_sel_ok

   // ****************************************
   // Counting datapath
   // ****************************************
   always_comb begin
      logic [2:0] sel0;
      logic [2:0] sel1;
      logic       m8_0;
      logic       m8_1;
      logic       m16;
      sel0    = st_reg.ctrl[0][CTL_SEL_LSB +: 3];
      sel1    = st_reg.ctrl[1][CTL_SEL_LSB +: 3];
      upper16 = st_reg.ctrl[1][CTL_MODE_LSB + MODE_16_BIT];
      m8_0    = ~upper16 & (st_reg.ctrl[0][CTL_MODE_LSB +: 3] == MODE_8_TIMER);
      m8_1    = ~upper16 & (st_reg.ctrl[1][CTL_MODE_LSB +: 3] == MODE_8_TIMER);
      m16     = upper16 & (st_reg.ctrl[1][CTL_MODE_LSB +: 3] == MODE_16_TIMER);
      fall[0] = st_reg.ev_sync[0][2] & ~st_reg.ev_sync[0][1];
      fall[1] = st_reg.ev_sync[1][2] & ~st_reg.ev_sync[1][1];
      run[0]  = upper16 ? st_reg.ctrl[1][CTL_RUN_BIT] : st_reg.ctrl[0][CTL_RUN_BIT];
      run[1]  = st_reg.ctrl[1][CTL_RUN_BIT];
      // Lower select drives 16-bit operation; pin is the lower pin there
      if (sel0 == SEL_PIN) begin
         tick[0] = (m8_0 | m16) & fall[0];
      end else begin
         tick[0] = (m8_0 | m16) & timer_sel_ok(sel0, low_speed_mode)
                   & tap_tick(sel0, st_reg, low_speed_mode);
      end
      if (upper16) begin
         tick[1] = m16 & carry_lo;
      end else if (sel1 == SEL_PIN) begin
         tick[1] = m8_1 & fall[1];
      end else begin
         tick[1] = m8_1 & timer_sel_ok(sel1, low_speed_mode)
                   & tap_tick(sel1, st_reg, low_speed_mode);
      end
      // Compare against live register values, no shadow copy
      match8[0] = m8_0 & run[0] & (count[0] == st_reg.period[0]);
      match8[1] = m8_1 & run[1] & (count[1] == st_reg.period[1]);
      match16   = m16 & run[1] & ({count[1], count[0]} == st_reg.period);
      clear[0]  = match8[0] | match16;
      clear[1]  = match8[1] | match16;
   end

   // ****************************************
   // Channel counters
   // ****************************************
   dtc_channel u_lower (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (run[0]),
      .tick    (tick[0]),
      .clear   (clear[0]),
      .count   (count[0]),
      .carry   (carry_lo)
   );

   dtc_channel u_upper (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (run[1]),
      .tick    (tick[1]),
      .clear   (clear[1]),
      .count   (count[1]),
      .carry   ()
   );

   // ****************************************
   // Next state: bus slave, prescaler, sync
   // ****************************************
   always_comb begin
      logic [31:0] rd;
      logic        hit;
      st_next = st_reg;
      rd      = 32'h0000_0000;
      hit     = 1'b1;
      st_next.pre = st_reg.pre + PRE_W'(1);
      if (st_reg.fs_cnt == FS_CNT_W'(FS_DIVIDE - 1)) begin
         st_next.fs_cnt = '0;
         st_next.fs_sub = st_reg.fs_sub + FS_SUB_W'(1);
      end else begin
         st_next.fs_cnt = st_reg.fs_cnt + FS_CNT_W'(1);
      end
      st_next.ev_sync[0] = {st_reg.ev_sync[0][1:0], event_input_pin_lower};
      st_next.ev_sync[1] = {st_reg.ev_sync[1][1:0], event_input_pin_upper};
      st_next.irq = {match8[1] | match16, match8[0]};
      // Write channels
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_have = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = RESP_OKAY;
         if (st_reg.w_strb[0]) begin
            unique case (st_reg.aw_addr)
               OFS_CTRL_LOWER:   st_next.ctrl[0]   = st_reg.w_data[7:0];
               OFS_CTRL_UPPER:   st_next.ctrl[1]   = st_reg.w_data[7:0];
               OFS_PERIOD_LOWER: st_next.period[0] = st_reg.w_data[7:0];
               OFS_PERIOD_UPPER: st_next.period[1] = st_reg.w_data[7:0];
               OFS_DUTY_LOWER:   st_next.duty[0]   = st_reg.w_data[7:0];
               OFS_DUTY_UPPER:   st_next.duty[1]   = st_reg.w_data[7:0];
               OFS_CONFIG:       st_next.tap_sel   = st_reg.w_data[CFG_TAP_BIT];
               OFS_COUNT:        st_next.bresp     = RESP_OKAY;
               default:          st_next.bresp     = RESP_SLVERR;
            endcase
         end
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      // Read channel
      unique case (s_axi_araddr)
         OFS_CTRL_LOWER:   rd[7:0] = st_reg.ctrl[0];
         OFS_CTRL_UPPER:   rd[7:0] = st_reg.ctrl[1];
         OFS_PERIOD_LOWER: rd[7:0] = st_reg.period[0];
         OFS_PERIOD_UPPER: rd[7:0] = st_reg.period[1];
         OFS_DUTY_LOWER:   rd[7:0] = st_reg.duty[0];
         OFS_DUTY_UPPER:   rd[7:0] = st_reg.duty[1];
         OFS_CONFIG:       rd[CFG_TAP_BIT] = st_reg.tap_sel;
         OFS_COUNT:        rd[15:0] = {count[1], count[0]};
         default:          hit = 1'b0;
      endcase
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd;
         st_next.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg        <= '0;
         st_reg.ctrl   <= {CTRL_RESET, CTRL_RESET};
         st_reg.period <= {PERIOD_RESET, PERIOD_RESET};
         st_reg.duty   <= {DUTY_RESET, DUTY_RESET};
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready         = ~st_reg.aw_have;
   assign s_axi_wready          = ~st_reg.w_have;
   assign s_axi_bvalid          = st_reg.bvalid;
   assign s_axi_bresp           = st_reg.bresp;
   assign s_axi_arready         = ~st_reg.rvalid;
   assign s_axi_rvalid          = st_reg.rvalid;
   assign s_axi_rdata           = st_reg.rdata;
   assign s_axi_rresp           = st_reg.rresp;
   assign match_interrupt_lower = st_reg.irq[0];
   assign match_interrupt_upper = st_reg.irq[1];
endmodule : dtc_timer
`default_nettype wire

// file: dtc_pkg.sv
// Constants shared by the dual 8-bit timer/event counter
package dtc_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL_LOWER   = 8'h00;
   localparam logic [7:0] OFS_CTRL_UPPER   = 8'h04;
   localparam logic [7:0] OFS_PERIOD_LOWER = 8'h08;
   localparam logic [7:0] OFS_PERIOD_UPPER = 8'h0c;
   localparam logic [7:0] OFS_DUTY_LOWER   = 8'h10;
   localparam logic [7:0] OFS_DUTY_UPPER   = 8'h14;
   localparam logic [7:0] OFS_CONFIG       = 8'h18;
   localparam logic [7:0] OFS_COUNT        = 8'h1c;
   localparam int         ADDR_W           = 8;
   // ****************************************
   // Control and config register fields, reset values
   // ****************************************
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_RUN_BIT  = 3;
   localparam int CTL_SEL_LSB  = 4;
   localparam int CTL_FF_BIT   = 7;
   localparam int CFG_TAP_BIT  = 0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [7:0] DUTY_RESET   = 8'hff;
   // ****************************************
   // Operating modes and clock selects
   // ****************************************
   localparam logic [2:0] MODE_8_TIMER  = 3'h0;
   localparam logic [2:0] MODE_16_TIMER = 3'h4;
   localparam logic [2:0] MODE_WARMUP   = 3'h5;
   localparam int         MODE_16_BIT   = 2;
   localparam logic [2:0] SEL_SLOWEST   = 3'h0;
   localparam logic [2:0] SEL_FC_128    = 3'h1;
   localparam logic [2:0] SEL_FC_32     = 3'h2;
   localparam logic [2:0] SEL_FC_8      = 3'h3;
   localparam logic [2:0] SEL_FS        = 3'h4;
   localparam logic [2:0] SEL_FC_2      = 3'h5;
   localparam logic [2:0] SEL_FC        = 3'h6;
   localparam logic [2:0] SEL_PIN       = 3'h7;
   // ****************************************
   // Clock rates, prescaler and event sync length
   // ****************************************
   localparam int CLK_HZ    = 125_000_000;
   localparam int FS_HZ     = 32_768;
   localparam int FS_DIV    = CLK_HZ / FS_HZ;
   localparam int PRE_W     = 11;
   localparam int FS_CNT_W  = 16;
   localparam int FS_SUB_W  = 3;
   localparam int SYNC_LEN  = 3;
   // ****************************************
   // Bus answers
   // ****************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dtc_pkg

// file: dtc_channel.sv
// One 8-bit up-counter channel with clear, tick and overflow carry
`timescale 1ns/1ps
`default_nettype none
module dtc_channel
   import dtc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       run,
   input  wire logic       tick,
   input  wire logic       clear,
   output logic      [7:0] count,
   output logic            carry
);
   typedef struct packed {
      logic [7:0] count;
   } dtc_ch_state_t;

   dtc_ch_state_t st_reg;
   dtc_ch_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!run) begin
         st_next.count = 8'h00;
      end else if (clear) begin
         st_next.count = 8'h00;
      end else if (tick) begin
         st_next.count = st_reg.count + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.count;
   assign carry = run & tick & ~clear & (st_reg.count == 8'hff);
endmodule : dtc_channel
`default_nettype wire

// file: dtc_timer_properties.sv
// Bus handshake and match pulse checks for the dual timer
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_properties (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        match_interrupt_lower,
   input wire logic        match_interrupt_upper
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_lo_pulse_once: assert property (match_interrupt_lower |=> !match_interrupt_lower)
      else $error("lower match pulse too long");
   a_up_pulse_once: assert property (match_interrupt_upper |=> !match_interrupt_upper)
      else $error("upper match pulse too long");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
endmodule : dtc_timer_properties
`default_nettype wire

// file: dtc_event_source.sv
// Falling-edge pulse source for an event pin
`timescale 1ns/1ps
`default_nettype none
module dtc_event_source (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       go,
   input  wire logic [3:0] width,
   output logic            pin
);
   int hold;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst || !go) begin
         pin  <= 1'h1;
         hold <= 0;
      end else if (hold >= 6 + width) begin
         pin  <= ~pin;
         hold <= 0;
      end else begin
         hold <= hold + 1;
      end
   end
endmodule : dtc_event_source
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the dual timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dtc_pkg::*;
   localparam int FSD = 4;
   logic        clk, sys_rst, awv, wv, bry, arv, rry, lspd, go;
   logic [7:0]  awa, ara;
   logic [31:0] wd;
   logic [3:0]  wid;
   logic [15:0] lf;
   wire logic   awr, wr, bv, arr, rv, irq_lo, irq_up, pin_up;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rd;
   int mismatches, n_compared, cyc, edges, e0, i, p, t0, t1;
   int shadow [8] = '{0, 0, 255, 255, 255, 255, 0, 0};
   logic [2:0] sel_t [8] = '{SEL_SLOWEST, SEL_FC_128, SEL_FC_32, SEL_FC_8,
                            SEL_SLOWEST, SEL_SLOWEST, SEL_FC, SEL_FC_8};
   int tap_t [8] = '{2048, 128, 32, 8, 8 * FSD, 8 * FSD, 0, 0};
   logic [1:0] mod_t [8] = '{0, 0, 0, 0, 1, 2, 0, 2};
   dtc_timer #(.FS_DIVIDE(FSD)) DUT (
      .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .event_input_pin_lower(1'h1), .event_input_pin_upper(pin_up), .low_speed_mode(lspd),
      .match_interrupt_lower(irq_lo), .match_interrupt_upper(irq_up));
   dtc_event_source u_src (.clk(clk), .sys_rst(sys_rst), .go(go), .width(wid), .pin(pin_up));
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
      chk(n, {30'h0, e}, {30'h0, g});
   endtask : chk_resp
   task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] rsp;
      tb = 1'h0;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      while (!tb) begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr;
         tb = bv;
         rsp = br;
         @(posedge clk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
      end
      bry <= 1'h0;
      chk("bvalid", 1, tb);
      chk_resp("bresp", er, rsp);
      // Let an edge pass so a following call never re-raises bready in this step
      @(posedge clk);
   endtask : wr32
   task automatic rd32(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic tr, tv;
      logic [31:0] dat;
      logic [1:0] rsp;
      tv = 1'h0;
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      while (!tv) begin
         @(negedge clk);
         tr = arv & arr;
         tv = rv;
         dat = rd;
         rsp = rr;
         @(posedge clk);
         if (tr) arv <= 1'h0;
      end
      rry <= 1'h0;
      if (er === RESP_OKAY) chk("rdata", e, dat);
      chk_resp("rresp", er, rsp);
      // Let an edge pass so a following call never re-raises rready in this step
      @(posedge clk);
   endtask : rd32
   task automatic wait_irq(input logic up, input int lim, output int at);
      at = -1;
      for (int t = 0; t < lim && at < 0; t++) begin
         @(negedge clk);
         if ((up ? irq_up : irq_lo) === 1'h1) at = cyc;
      end
      // Return on a rising edge so the next bus request starts there
      @(posedge clk);
   endtask : wait_irq
   task automatic end_of_test();
      if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   always @(negedge pin_up) edges++;
   initial begin
      #600000;
      mismatches++;
      end_of_test();
   end
   initial begin
      sys_rst = 1'h1;
      {awv, wv, bry, arv, rry, lspd, go} = 7'h00;
      {awa, ara, wd, wid} = 52'h0;
      lf = 16'h0041;
      repeat (5) @(posedge clk);
      sys_rst <= 1'h0;
      for (i = 0; i < 8; i++) rd32(8'(i * 4), shadow[i], RESP_OKAY);
      rd32(8'h20, 0, RESP_SLVERR);
      wr32(8'h24, 32'h55, RESP_SLVERR);
      for (i = 0; i < 8; i++) begin
         p = 1 + (lf % 4);
         lf = lfsr_next(lf);
         lspd <= mod_t[i][1];
         wr32(OFS_CONFIG, {31'h0, mod_t[i][0]}, RESP_OKAY);
         wr32(OFS_PERIOD_LOWER, p, RESP_OKAY);
         wr32(OFS_CTRL_LOWER, {25'h0, sel_t[i], 1'h1, MODE_8_TIMER}, RESP_OKAY);
         if (tap_t[i] > 0) begin
            wait_irq(1'h0, 2 * p * tap_t[i] + 100, t0);
            wait_irq(1'h0, 2 * p * tap_t[i] + 100, t1);
            chk("interval", p * tap_t[i], t1 - t0);
         end else begin
            wait_irq(1'h0, 600, t0);
            chk("silent", 32'hffffffff, t0);
         end
         wr32(OFS_CTRL_LOWER, {25'h0, sel_t[i], 1'h0, MODE_8_TIMER}, RESP_OKAY);
         rd32(OFS_COUNT, 0, RESP_OKAY);
      end
      lspd <= 1'h0;
      wr32(OFS_PERIOD_LOWER, 3, RESP_OKAY);
      wr32(OFS_CTRL_LOWER, {25'h0, SEL_FC_8, 1'h1, MODE_8_TIMER}, RESP_OKAY);
      wait_irq(1'h0, 200, t0);
      wr32(OFS_PERIOD_LOWER, 9, RESP_OKAY);
      wait_irq(1'h0, 200, t1);
      chk("new period", 72, t1 - t0);
      wr32(OFS_CTRL_LOWER, {25'h0, SEL_FC_8, 1'h0, MODE_8_TIMER}, RESP_OKAY);
      // Cascade: lower select drives, upper select must be ignored
      wr32(OFS_PERIOD_UPPER, 1, RESP_OKAY);
      wr32(OFS_PERIOD_LOWER, p, RESP_OKAY);
      wr32(OFS_CTRL_UPPER, {25'h0, SEL_FC_32, 1'h1, MODE_16_TIMER}, RESP_OKAY);
      wait_irq(1'h1, 2 * (256 + p) * tap_t[3] + 100, t0);
      wait_irq(1'h1, 2 * (256 + p) * tap_t[3] + 100, t1);
      chk("interval16", (256 + p) * tap_t[3], t1 - t0);
      wr32(OFS_CTRL_UPPER, {25'h0, SEL_FC_32, 1'h0, MODE_16_TIMER}, RESP_OKAY);
      rd32(OFS_COUNT, 0, RESP_OKAY);
      p = 2 + (lf % 4);
      wid <= lf[3:0];
      wr32(OFS_PERIOD_UPPER, p, RESP_OKAY);
      wr32(OFS_CTRL_UPPER, {25'h0, SEL_PIN, 1'h1, MODE_8_TIMER}, RESP_OKAY);
      e0 = edges;
      go <= 1'h1;
      for (i = 0; i < 3; i++) begin
         wait_irq(1'h1, 1500, t0);
         chk("edges per match", p, edges - e0);
         e0 = edges;
      end
      end_of_test();
   end
endmodule : tb_top
bind dtc_timer dtc_timer_properties u_props (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .match_interrupt_lower,
   .match_interrupt_upper);
`default_nettype wire
